// file: keyboard_interrupt_unit.sv
// Keypad interrupt unit with an AHB-Lite register slave.
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module keyboard_interrupt_unit
  import keypad_irq_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic      [1:0]           hresp,
  input  wire logic [PIN_COUNT-1:0] key_pin,
  input  wire logic [PIN_COUNT-1:0] pin_direction,
  input  wire logic                 vector_fetch,
  input  wire logic                 break_state,
  output logic      [PIN_COUNT-1:0] pullup_enable,
  output logic      [PIN_COUNT-1:0] pin_output_enable,
  output logic                      cpu_request,
  output logic                      wake_request
);
  import keypad_irq_pkg::*;

  // Register fields.
  logic [PIN_COUNT-1:0] pin_enable_bits;
  logic                 trigger_sense_select;
  logic                 request_mask;
  logic                 break_clear_enable;
  logic                 pending_flag;
  logic                 ack_seen;

  // Pin path.
  logic [PIN_COUNT-1:0] sync_pin;
  logic [PIN_COUNT-1:0] pin_low;
  logic                 any_low;
  logic                 any_low_prev;
  logic                 new_fall;

  // Bus path.
  logic                 addr_valid;
  logic                 addr_read;
  logic                 read_status;
  logic                 read_enable;
  logic                 read_break;
  logic                 dp_valid;
  logic                 dp_write;
  logic [31:0]          dp_addr;
  logic                 dp_write_valid;
  logic                 write_status;
  logic                 write_enable;
  logic                 write_break;

  // Acknowledge and request path.
  logic                 ack_allowed;
  logic                 ack_write;
  logic                 acknowledge;
  logic                 edge_pending;
  logic                 level_pending;
  logic                 level_ack_seen;
  logic                 next_pending;
  logic                 next_ack_seen;

  // Readback path.
  logic [7:0]           status_view;
  logic [7:0]           enable_view;
  logic [7:0]           break_view;
  logic [31:0]          next_hrdata;

  // One synchroniser per pin.
  // Its idle level is high, so a pin at rest gives no false fall after reset.
  for (genvar pin = 0; pin < PIN_COUNT; pin = pin + 1) begin : g_pin_sync
    pin_sync_stage #(
      .IDLE_LEVEL (1'b1)
    ) sync_stage (
      .clk      (clk),
      .rstn     (rstn),
      .raw_pin  (key_pin[pin]),
      .safe_pin (sync_pin[pin])
    );
  end

  assign pin_low = ~sync_pin & pin_enable_bits;
  assign any_low = |pin_low;

  // Previous level for edge detection.
  // Its reset value matches the idle level, so no false edge follows reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      any_low_prev <= 1'b0;
    end else begin
      any_low_prev <= any_low;
    end
  end

  // No edge while one stays low.
  // A pin that stays low hides a later fall on another pin; software may disable it.
  assign new_fall = any_low & ~any_low_prev;

  // AHB-Lite slave: zero wait states, always OKAY.
  // Only whole-word transfers are used, so hsize is not decoded.
  assign addr_valid = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign addr_read  = addr_valid & ~hwrite;

  // Address phase decode of reads.
  assign read_status = addr_read & (haddr == STATUS_CONTROL_OFFSET);
  assign read_enable = addr_read & (haddr == PIN_ENABLE_OFFSET);
  assign read_break  = addr_read & (haddr == BREAK_CONTROL_OFFSET);

  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // Data phase qualifier.
  // Address phase fields are taken only when the bus moves on.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dp_valid <= 1'b0;
    end else if (hready) begin
      dp_valid <= addr_valid;
    end
  end

  // Data phase direction.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dp_write <= 1'b0;
    end else if (hready) begin
      dp_write <= hwrite;
    end
  end

  // Data phase address.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dp_addr <= 32'h0000_0000;
    end else if (hready) begin
      dp_addr <= haddr;
    end
  end

  // A write whose data stands on the bus in this cycle.
  assign dp_write_valid = dp_valid & dp_write;

  // Write strobes, one per register.
  assign write_status = dp_write_valid & (dp_addr == STATUS_CONTROL_OFFSET);
  assign write_enable = dp_write_valid & (dp_addr == PIN_ENABLE_OFFSET);
  assign write_break  = dp_write_valid & (dp_addr == BREAK_CONTROL_OFFSET);

  // Break protection of the acknowledge.
  // Without it a debugger stepping through the handler would lose the flag.
  assign ack_allowed = ~break_state | break_clear_enable;

  // Software and vector fetch acknowledge.
  // The vector fetch is taken as given; it is not gated by the break state.
  assign ack_write   = write_status & hwdata[ACK_BIT] & ack_allowed;
  assign acknowledge = ack_write | vector_fetch;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trigger_sense_select <= 1'b0;
    end else if (write_status) begin
      trigger_sense_select <= hwdata[MODE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      request_mask <= 1'b0;
    end else if (write_status) begin
      request_mask <= hwdata[MASK_BIT];
    end
  end

  // Pin enables.
  // Enabling a pin whose pullup has not yet settled can latch a false request.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_enable_bits <= PIN_ENABLE_RESET;
    end else if (write_enable) begin
      pin_enable_bits <= hwdata[PIN_COUNT-1:0];
    end
  end

  // Break clear enable.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      break_clear_enable <= 1'b0;
    end else if (write_break) begin
      break_clear_enable <= hwdata[BREAK_CLEAR_BIT];
    end
  end

  // Edge mode: an acknowledge clears at once.
  always_comb begin
    edge_pending = pending_flag;
    if (acknowledge) begin
      edge_pending = 1'b0;
    end
  end

  // Level mode: a low pin holds the request.
  // Clear needs an acknowledge and all pins high, in either order.
  always_comb begin
    level_pending = pending_flag;
    if (any_low) begin
      level_pending = 1'b1;
    end
    if ((acknowledge || ack_seen) && !any_low) begin
      level_pending = 1'b0;
    end
  end

  // An acknowledge is remembered only while a request is pending.
  always_comb begin
    level_ack_seen = ack_seen;
    if (acknowledge) begin
      level_ack_seen = pending_flag;
    end
    if ((acknowledge || ack_seen) && !any_low) begin
      level_ack_seen = 1'b0;
    end
  end

  // A fresh fall relatches; it wins over an acknowledge in the same cycle.
  always_comb begin
    if (trigger_sense_select) begin
      next_pending  = level_pending;
      next_ack_seen = level_ack_seen;
    end else begin
      next_pending  = edge_pending;
      next_ack_seen = 1'b0;
    end
    if (new_fall) begin
      next_pending  = 1'b1;
      next_ack_seen = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending_flag <= 1'b0;
    end else begin
      pending_flag <= next_pending;
    end
  end

  // Remembered acknowledge for level mode.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_seen <= 1'b0;
    end else begin
      ack_seen <= next_ack_seen;
    end
  end

  // Mask gates the CPU path, and the wake request with it.
  assign cpu_request = pending_flag & ~request_mask;

  assign wake_request = cpu_request;

  assign pullup_enable = pin_enable_bits;

  assign pin_output_enable = pin_direction & ~pin_enable_bits;

  // Pending flag as the reader will see it.
  // Acknowledge reads zero.
  // The flag is taken from its next value, so a read sees an event of the same cycle.
  always_comb begin
    status_view              = 8'h00;
    status_view[PENDING_BIT] = next_pending;
    status_view[MASK_BIT]    = request_mask;
    status_view[MODE_BIT]    = trigger_sense_select;
  end

  assign enable_view = {{(8 - PIN_COUNT){1'b0}}, pin_enable_bits};

  // Break control readback.
  always_comb begin
    break_view                  = 8'h00;
    break_view[BREAK_CLEAR_BIT] = break_clear_enable;
  end

  // Unmapped addresses and writes read as zero.
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (read_status) begin
      next_hrdata[7:0] = status_view;
    end else if (read_enable) begin
      next_hrdata[7:0] = enable_view;
    end else if (read_break) begin
      next_hrdata[7:0] = break_view;
    end
  end

  // Read data stands for one data phase only.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

endmodule // keyboard_interrupt_unit

// Two-stage synchroniser for one pin; only the second stage is read outside.
module pin_sync_stage
#(
  parameter logic IDLE_LEVEL = 1'b1
)
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic raw_pin,
  output logic      safe_pin
);
  logic first_stage;

  // First stage may go metastable, so nothing but the second stage reads it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_stage <= IDLE_LEVEL;
    end else begin
      first_stage <= raw_pin;
    end
  end

  // Second stage is the only output.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      safe_pin <= IDLE_LEVEL;
    end else begin
      safe_pin <= first_stage;
    end
  end

endmodule // pin_sync_stage

// file: keypad_irq_pkg.sv
// Package with register map, field positions and reset values of the keypad interrupt unit.
package keypad_irq_pkg;
  localparam int unsigned PIN_COUNT = 5;
  localparam logic [31:0] STATUS_CONTROL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] PIN_ENABLE_OFFSET     = 32'h0000_0004;
  localparam logic [31:0] BREAK_CONTROL_OFFSET  = 32'h0000_0008;
  localparam int unsigned MODE_BIT    = 0;
  localparam int unsigned MASK_BIT    = 1;
  localparam int unsigned ACK_BIT     = 2;
  localparam int unsigned PENDING_BIT = 3;
  localparam int unsigned BREAK_CLEAR_BIT = 0;
  localparam logic [4:0] PIN_ENABLE_RESET = 5'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;
endpackage

// file: keypad_switches.sv
// Keypad switch model: a pressed key pulls its pin low.
`timescale 1ns/1ns
module keypad_switches (
  input  wire logic       clk,
  input  wire logic [4:0] pullup_enable,
  input  wire logic [4:0] pressed,
  output logic      [4:0] key_pin
);
  logic [4:0] wobble = 5'h0a;
  // A released pin with no pullup floats, so it toggles instead of keeping its level.
  always @(posedge clk) wobble <= ~wobble;
  assign key_pin = ~pressed & (pullup_enable | wobble);
endmodule // keypad_switches

// file: keyboard_interrupt_unit_props.sv
// Assertions on the ports of the keypad interrupt unit.
`timescale 1ns/1ns
module kiu_props
  import keypad_irq_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic                 hsel,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic [31:0]          hrdata,
  input wire logic                 hreadyout,
  input wire logic [1:0]           hresp,
  input wire logic [PIN_COUNT-1:0] key_pin,
  input wire logic [PIN_COUNT-1:0] pin_direction,
  input wire logic [PIN_COUNT-1:0] pullup_enable,
  input wire logic [PIN_COUNT-1:0] pin_output_enable,
  input wire logic                 cpu_request,
  input wire logic                 wake_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic wr = hsel && hready && htrans[1] && hwrite;
  wire logic rd = hsel && hready && htrans[1] && !hwrite;
  a_pin_dir: assert property (pin_output_enable == (pin_direction & ~pullup_enable))
    else $error("enabled pin not forced to input");
  a_wake_same: assert property (wake_request == cpu_request)
    else $error("wake differs from request");
  a_resp_okay: assert property (hresp == HRESP_OKAY && hreadyout)
    else $error("bus response not okay");
  a_reset_quiet: assert property ($rose(rstn) |-> !cpu_request && pullup_enable == 5'h00)
    else $error("state left after reset");
  a_read_idle: assert property (!$past(rd) |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  a_pull_bus: assert property (!$stable(pullup_enable) |-> $past(wr, 2))
    else $error("enables changed without write");
  a_req_cause: assert property ($rose(cpu_request) |->
    $past(wr, 2) || |(~$past(key_pin, 3) & $past(pullup_enable, 3)))
    else $error("request without enabled low pin");
  cover property ($rose(cpu_request));
  cover property ($fell(cpu_request) && |(~key_pin & pullup_enable));
  cover property ($rose(|pullup_enable));
endmodule // kiu_props
bind keyboard_interrupt_unit kiu_props props (
  .clk               (clk),
  .rstn              (rstn),
  .hsel              (hsel),
  .htrans            (htrans),
  .hwrite            (hwrite),
  .hready            (hready),
  .hrdata            (hrdata),
  .hreadyout         (hreadyout),
  .hresp             (hresp),
  .key_pin           (key_pin),
  .pin_direction     (pin_direction),
  .pullup_enable     (pullup_enable),
  .pin_output_enable (pin_output_enable),
  .cpu_request       (cpu_request),
  .wake_request      (wake_request)
);

// file: tb_top.sv
// Self-checking bench for the keypad interrupt unit.
`timescale 1ns/1ns
module tb_top;
  import keypad_irq_pkg::*;
  logic clk, rstn, hsel, hwrite, hreadyout, vector_fetch, break_state, cpu_request, wake_request;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize = 3'h2;
  logic [4:0] key_pin, pin_direction, pullup_enable, pin_output_enable, pressed;
  wire logic hready = hreadyout;
  int bad_count, checks_done, cycles;
  keyboard_interrupt_unit dut (
    .clk               (clk),
    .rstn              (rstn),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hready),
    .hrdata            (hrdata),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .key_pin           (key_pin),
    .pin_direction     (pin_direction),
    .vector_fetch      (vector_fetch),
    .break_state       (break_state),
    .pullup_enable     (pullup_enable),
    .pin_output_enable (pin_output_enable),
    .cpu_request       (cpu_request),
    .wake_request      (wake_request)
  );
  keypad_switches sw (.clk(clk), .pullup_enable(pullup_enable), .pressed(pressed), .key_pin(key_pin));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task end_of_test;
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) if (++cycles > 3000) begin
    bad_count++;
    end_of_test;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1; haddr <= a; hwrite <= w; htrans <= HTRANS_NONSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task ws(input logic [31:0] d);
    xfer(STATUS_CONTROL_OFFSET, 1, d);
  endtask
  task rs(input logic [31:0] e);
    xfer(STATUS_CONTROL_OFFSET, 0, 0);
    chk(q, e);
  endtask
  task settle(input logic [4:0] p);
    pressed <= p;
    repeat (5) @(posedge clk);
  endtask
  initial begin
    rstn = 0; hsel = 0; haddr = 0; hwrite = 0; htrans = 0; hwdata = 0; vector_fetch = 0;
    break_state = 0; pin_direction = 5'h1f; pressed = 0;
    repeat (4) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rs(8'h00);
    xfer(PIN_ENABLE_OFFSET, 0, 0); chk(q, 8'h00);
    xfer(32'h0000_0010, 0, 0); chk(q, 8'h00);
    ws(8'hf2); xfer(PIN_ENABLE_OFFSET, 1, 8'h1f); rs(8'h0a);
    chk(cpu_request, 0);
    xfer(PIN_ENABLE_OFFSET, 0, 0); chk(q, 8'h1f);
    chk(pullup_enable, 8'h1f);
    ws(8'h04); ws(8'h00);
    settle(5'h01); rs(8'h08);
    chk(cpu_request, 1);
    pressed <= 5'h03; ws(8'h04); rs(8'h00);
    settle(5'h03); rs(8'h00);
    settle(5'h00); settle(5'h04); rs(8'h08);
    vector_fetch <= 1; @(posedge clk); vector_fetch <= 0; rs(8'h00);
    settle(5'h00); ws(8'h02); settle(5'h08); rs(8'h0a);
    chk(cpu_request, 0);
    settle(5'h00); ws(8'h06); rs(8'h02);
    ws(8'h01); settle(5'h10); ws(8'h05); rs(8'h09);
    chk(wake_request, 1);
    settle(5'h00); rs(8'h01);
    settle(5'h10); settle(5'h00); rs(8'h09);
    ws(8'h05); rs(8'h01);
    ws(8'h00); break_state <= 1; settle(5'h01); ws(8'h04); rs(8'h08);
    xfer(BREAK_CONTROL_OFFSET, 1, 1); ws(8'h04); break_state <= 0; rs(8'h00);
    settle(5'h00); xfer(PIN_ENABLE_OFFSET, 1, 8'h1e); settle(5'h01); rs(8'h00);
    ws(8'h01); settle(5'h02); rstn <= 0; repeat (2) @(posedge clk); rstn <= 1;
    @(posedge clk); rs(8'h00);
    chk(pullup_enable, 8'h00);
    end_of_test;
  end
endmodule // tb_top
